// file: verilog/cbtc_pkg.sv
package cbtc_pkg;
  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [3:0] CBTC_CFG_ADDR = 4'h0;
  localparam logic [3:0] CBTC_CTL_ADDR = 4'h4;
  localparam logic [3:0] CBTC_STAT_ADDR = 4'h8;
  localparam logic [31:0] CBTC_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CBTC_CFG_MASK = 32'h0047_ffff;
  localparam logic [31:0] CBTC_UNMAPPED = 32'h0000_0000;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CBTC_WAKE_LINE_FILTER_EN_BIT = 22;
  localparam int CBTC_PS2_LSB = 16;
  localparam int CBTC_PS2SEL_BIT = 15;
  localparam int CBTC_SAM_BIT = 14;
  localparam int CBTC_PS1_LSB = 11;
  localparam int CBTC_PRS_LSB = 8;
  localparam int CBTC_SJW_LSB = 6;
  localparam int CBTC_BRP_LSB = 0;
  localparam int CBTC_MODE_LSB = 21;
  localparam logic [2:0] CBTC_MODE_CONFIG = 3'h4;
  localparam logic [2:0] CBTC_MODE_RESET = 3'h4;
  localparam logic [3:0] CBTC_IPT_TQ = 4'h2;
  localparam logic [3:0] CBTC_SYNC_TQ = 4'h1;
  localparam logic [1:0] CBTC_SAMPLES_ONE = 2'h1;
  localparam logic [1:0] CBTC_SAMPLES_THREE = 2'h3;
  typedef enum logic [1:0] {
    CBTC_IDLE = 2'b01,
    CBTC_ACK = 2'b10
  } cbtc_bus_t;
endpackage

// file: verilog/cbtc_tq_div.sv
`timescale 1ns/10ps
module cbtc_tq_div
  import cbtc_pkg::*;
#(
  parameter int BRP_W = 6
)
(
  input wire logic MCLK, // module clock
  input wire logic RST_N, // async reset, active low
  input wire logic [BRP_W-1:0] BAUD_PRESCALER, // prescaler value
  input wire logic CLR, // restart the quantum count
  output logic TQ_TICK // one-cycle pulse per time quantum
);
  typedef struct packed {
    logic [BRP_W:0] cnt;
    logic tick;
  } cbtc_div_t;
  cbtc_div_t st_r, st_nxt;
  logic [BRP_W:0] term;

  // --------------------------------------------------------------------
  // quantum is 2*(brp+1) clocks
  // --------------------------------------------------------------------
  always_comb
  begin
    term = {BAUD_PRESCALER, 1'b1};
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (CLR || st_r.cnt >= term)
    begin
      st_nxt.cnt = '0;
      st_nxt.tick = !CLR;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign TQ_TICK = st_r.tick;

  chk_tick_spacing: assert property (@(posedge MCLK) disable iff (!RST_N)
    TQ_TICK || CLR |=> !TQ_TICK)
    else $error("quantum ticks too close");
endmodule

// file: verilog/cbtc_top.sv
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - wake-up filter bit 22 routes the bus line through a line filter.
// - phase segment 2 field bits 18:16 give value plus one quanta.
// - select bit 15 set makes segment 2 free, else max(seg1, IPT).
// - sample bit 14 set takes three samples, else one.
// - phase segment 1 field bits 13:11 give value plus one quanta.
// - with select clear the programmed seg2 field is ignored.
// - config register writable only in configuration mode 100.
module cbtc_top
  import cbtc_pkg::*;
#(
  parameter int BRP_W = 6
)
(
  input wire logic MCLK, // module clock, 10 MHz
  input wire logic RST_N, // async reset, active low
  input wire logic [3:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [3:0] AVS_BYTEENABLE, // write lanes
  input wire logic [31:0] AVS_WRITEDATA, // write data
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // bus stall
  input wire logic CAN_RX, // raw bus line pin
  output logic WAKE_RX, // line used for wake-up detection
  output logic SAMPLED_BIT, // bus value at sample point, voted in three-sample mode
  output logic TQ_TICK, // time quantum pulse
  output logic [3:0] SEG_PROP_TQ, // propagation quanta
  output logic [3:0] SEG_PH1_TQ, // phase 1 quanta
  output logic [3:0] SEG_PH2_TQ, // phase 2 quanta
  output logic [3:0] SJW_TQ, // jump width quanta
  output logic [1:0] SAMPLE_COUNT // samples per bit
);
  typedef struct packed {
    cbtc_bus_t bus;
    logic [31:0] cfg;
    logic [2:0] mode;
    logic [31:0] rdata;
    logic [1:0] rx_sync;
    logic [2:0] hist;
    logic [1:0] filt;
    logic wake;
    logic smp;
    logic [3:0] ph1;
    logic [3:0] ph2;
    logic [3:0] prs;
    logic [3:0] sync_jump_width;
  } cbtc_state_t;
  cbtc_state_t st_r, st_nxt;

  logic rx_meta_r;
  logic div_clr;
  logic [3:0] p1;
  logic [3:0] p2;
  logic [31:0] wmask;
  logic cfg_mode;
  logic voted;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      rx_meta_r <= 1'b1;
    else
      rx_meta_r <= CAN_RX;
  end

  cbtc_tq_div #(.BRP_W(BRP_W)) u_div (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .BAUD_PRESCALER(st_r.cfg[CBTC_BRP_LSB +: BRP_W]),
    .CLR(div_clr),
    .TQ_TICK(TQ_TICK)
  );

  // --------------------------------------------------------------------
  // bus slave and segment decode
  // --------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    cfg_mode = (st_r.mode == CBTC_MODE_CONFIG);
    div_clr = cfg_mode;
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = {8{AVS_BYTEENABLE[i]}};
    st_nxt.rx_sync = {st_r.rx_sync[0], rx_meta_r};
    case (st_r.bus)
      CBTC_IDLE:
      begin
        if (AVS_WRITE)
        begin
          st_nxt.bus = CBTC_ACK;
          if (AVS_ADDRESS == CBTC_CFG_ADDR && cfg_mode)
            st_nxt.cfg = ((st_r.cfg & ~wmask) | (AVS_WRITEDATA & wmask))
              & CBTC_CFG_MASK;
          if (AVS_ADDRESS == CBTC_CTL_ADDR && AVS_BYTEENABLE[2])
            st_nxt.mode = AVS_WRITEDATA[CBTC_MODE_LSB +: 3];
        end
        else if (AVS_READ)
        begin
          st_nxt.bus = CBTC_ACK;
          case (AVS_ADDRESS)
            CBTC_CFG_ADDR: st_nxt.rdata = st_r.cfg;
            CBTC_CTL_ADDR:
              st_nxt.rdata = 32'(st_r.mode) << CBTC_MODE_LSB;
            CBTC_STAT_ADDR:
              st_nxt.rdata = {16'h0000, st_r.sync_jump_width, st_r.prs,
                st_r.ph1, st_r.ph2};
            default: st_nxt.rdata = CBTC_UNMAPPED;
          endcase
        end
      end
      CBTC_ACK: st_nxt.bus = CBTC_IDLE;
      default: st_nxt.bus = CBTC_IDLE;
    endcase
    p1 = {1'b0, st_r.cfg[CBTC_PS1_LSB +: 3]} + 4'h1;
    if (st_r.cfg[CBTC_PS2SEL_BIT])
      p2 = {1'b0, st_r.cfg[CBTC_PS2_LSB +: 3]} + 4'h1;
    else
      p2 = (p1 > CBTC_IPT_TQ) ? p1 : CBTC_IPT_TQ;
    st_nxt.ph1 = p1;
    st_nxt.ph2 = p2;
    st_nxt.prs = {1'b0, st_r.cfg[CBTC_PRS_LSB +: 3]} + 4'h1;
    st_nxt.sync_jump_width = {2'b00, st_r.cfg[CBTC_SJW_LSB +: 2]} + 4'h1;
    // majority of three quantum-spaced samples, or the latest one
    if (TQ_TICK)
      st_nxt.hist = {st_r.hist[1:0], st_r.rx_sync[1]};
    voted = (st_r.hist[0] & st_r.hist[1]) | (st_r.hist[1] & st_r.hist[2])
      | (st_r.hist[0] & st_r.hist[2]);
    st_nxt.smp = st_r.cfg[CBTC_SAM_BIT] ? voted : st_r.hist[0];
    // two-sample glitch filter used for wake-up only when enabled
    st_nxt.filt = {st_r.filt[0], st_r.rx_sync[1]};
    if (st_r.cfg[CBTC_WAKE_LINE_FILTER_EN_BIT])
    begin
      if (st_r.filt[0] == st_r.filt[1])
        st_nxt.wake = st_r.filt[1];
    end
    else
      st_nxt.wake = st_r.rx_sync[1];
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r <= '0;
      st_r.bus <= CBTC_IDLE;
      st_r.cfg <= CBTC_CFG_RESET;
      st_r.mode <= CBTC_MODE_RESET;
      st_r.rx_sync <= 2'b11;
      st_r.hist <= 3'b111;
      st_r.filt <= 2'b11;
      st_r.wake <= 1'b1;
      st_r.smp <= 1'b1;
      st_r.ph1 <= CBTC_SYNC_TQ;
      st_r.ph2 <= CBTC_IPT_TQ;
      st_r.prs <= CBTC_SYNC_TQ;
      st_r.sync_jump_width <= CBTC_SYNC_TQ;
    end
    else
      st_r <= st_nxt;
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && st_r.bus != CBTC_ACK;
  assign AVS_READDATA = st_r.rdata;
  assign WAKE_RX = st_r.wake;
  assign SAMPLED_BIT = st_r.smp;
  assign SEG_PROP_TQ = st_r.prs;
  assign SEG_PH1_TQ = st_r.ph1;
  assign SEG_PH2_TQ = st_r.ph2;
  assign SJW_TQ = st_r.sync_jump_width;
  assign SAMPLE_COUNT = st_r.cfg[CBTC_SAM_BIT] ? CBTC_SAMPLES_THREE
    : CBTC_SAMPLES_ONE;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  chk_cfg_locked: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_r.mode != CBTC_MODE_CONFIG |=> $stable(st_r.cfg))
    else $error("config changed outside configuration mode");
  chk_ph2_auto: assert property (@(posedge MCLK) disable iff (!RST_N)
    !st_r.cfg[CBTC_PS2SEL_BIT] && $stable(st_r.cfg) |=>
    SEG_PH2_TQ == ((SEG_PH1_TQ > CBTC_IPT_TQ) ? SEG_PH1_TQ : CBTC_IPT_TQ))
    else $error("automatic phase 2 wrong");
  chk_ph2_free: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_r.cfg[CBTC_PS2SEL_BIT] && $stable(st_r.cfg) |->
    SEG_PH2_TQ == {1'b0, st_r.cfg[CBTC_PS2_LSB +: 3]} + 4'h1)
    else $error("programmed phase 2 wrong");
  chk_ph1_len: assert property (@(posedge MCLK) disable iff (!RST_N)
    $stable(st_r.cfg) |->
    SEG_PH1_TQ == {1'b0, st_r.cfg[CBTC_PS1_LSB +: 3]} + 4'h1)
    else $error("phase 1 wrong");
  chk_prop_sjw: assert property (@(posedge MCLK) disable iff (!RST_N)
    $stable(st_r.cfg) |->
    SEG_PROP_TQ == {1'b0, st_r.cfg[CBTC_PRS_LSB +: 3]} + 4'h1
    && SJW_TQ == {2'b00, st_r.cfg[CBTC_SJW_LSB +: 2]} + 4'h1)
    else $error("prop or jump width wrong");
  chk_single_sample: assert property (@(posedge MCLK) disable iff (!RST_N)
    !st_r.cfg[CBTC_SAM_BIT] |=> SAMPLED_BIT == $past(st_r.hist[0]))
    else $error("single sample wrong");
  chk_wake_direct: assert property (@(posedge MCLK) disable iff (!RST_N)
    !st_r.cfg[CBTC_WAKE_LINE_FILTER_EN_BIT] |=> WAKE_RX == $past(st_r.rx_sync[1]))
    else $error("unfiltered wake line wrong");
  chk_wake_filter: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_r.cfg[CBTC_WAKE_LINE_FILTER_EN_BIT] && st_r.filt[0] != st_r.filt[1] |=>
    $stable(WAKE_RX)) else $error("filter passed a glitch");
  chk_bus_answer: assert property (@(posedge MCLK) disable iff (!RST_N)
    (AVS_READ || AVS_WRITE) && st_r.bus == CBTC_IDLE |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  cov_cfg_write: cover property (@(posedge MCLK) disable iff (!RST_N)
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == CBTC_CFG_ADDR);
  cov_locked_write: cover property (@(posedge MCLK) disable iff (!RST_N)
    AVS_WRITE && !cfg_mode && AVS_ADDRESS == CBTC_CFG_ADDR);
  cov_triple: cover property (@(posedge MCLK) disable iff (!RST_N)
    st_r.cfg[CBTC_SAM_BIT] && TQ_TICK);
  cov_wake_filt: cover property (@(posedge MCLK) disable iff (!RST_N)
    st_r.cfg[CBTC_WAKE_LINE_FILTER_EN_BIT] && $fell(WAKE_RX));
endmodule

// file: verif/cbtc_node_model.sv
`timescale 1ns/10ps
// ----------------------------------------------
// far bus node: dominant pulses on request
// ----------------------------------------------
module cbtc_node_model
(
  input wire logic mclk, // module clock
  input wire logic go, // start a dominant pulse
  input wire logic [3:0] len, // pulse length in clocks
  output logic line // bus line, recessive high
);
  int n = 0;
  always @(posedge mclk)
  begin
    if (go)
      n <= len;
    else if (n > 0)
      n <= n - 1;
  end
  // idle bus rests recessive
  assign line = (n == 0);
endmodule

// file: verif/can_bit_timing_config_tb_top.sv
`timescale 1ns/10ps
module can_bit_timing_config_tb_top
  import cbtc_pkg::*;
;
  logic mclk = 0, rst_n = 0, rd_en = 0, wr_en = 0, go = 0;
  logic [3:0] addr = 0, len = 0, prop, ph1, ph2, sync_jump_width;
  logic [31:0] wdata = 0, rdata, rd, c;
  logic wreq, line, wake, samp, tick;
  logic [1:0] scnt;
  int err_total = 0, cmp_count = 0, cyc = 0;
  initial forever #50 mclk = ~mclk;
  cbtc_node_model node (.mclk(mclk), .go(go), .len(len), .line(line));
  cbtc_top uut (.MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_BYTEENABLE(4'hf),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .CAN_RX(line), .WAKE_RX(wake),
    .SAMPLED_BIT(samp), .TQ_TICK(tick), .SEG_PROP_TQ(prop),
    .SEG_PH1_TQ(ph1), .SEG_PH2_TQ(ph2), .SJW_TQ(sync_jump_width),
    .SAMPLE_COUNT(scnt));
  // ----------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge mclk);
    while (wreq !== 1'b0)
      @(posedge mclk);
    rd = rdata;
    wr_en <= 0;
    rd_en <= 0;
  endtask
  task pulse(input logic [3:0] l);
    @(posedge mclk);
    go <= 1;
    len <= l;
    @(posedge mclk);
    go <= 0;
  endtask
  task chk_segs(input logic [15:0] e);
    repeat (2) @(negedge mclk);
    cmp("segments", {16'h0, e}, {16'h0, sync_jump_width, prop, ph1, ph2});
  endtask
  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task t_reset;
    bus(0, CBTC_CFG_ADDR, 0);
    cmp("cfg", CBTC_CFG_RESET, rd);
    chk_segs(16'h1112);
    cmp("samples", 32'(CBTC_SAMPLES_ONE), 32'(scnt));
    bus(0, 4'hc, 0);
    cmp("unmapped", CBTC_UNMAPPED, rd);
    $display("test reset done");
  endtask
  task t_auto_ph2;
    int p;
    for (int i = 0; i < 2; i++)
    begin
      p = i * 4 + 1;
      bus(1, CBTC_CFG_ADDR, 32'h0007_0400 | ((p - 1) << 11));
      chk_segs({8'h15, 4'(p), 4'(p > CBTC_IPT_TQ ? p : CBTC_IPT_TQ)});
    end
    $display("test auto segment 2 done");
  endtask
  task t_free;
    bus(1, CBTC_CFG_ADDR, 32'h8043_ea42);
    chk_segs(16'h2364);
    cmp("samples", 32'(CBTC_SAMPLES_THREE), 32'(scnt));
    bus(0, CBTC_CFG_ADDR, 0);
    cmp("cfg", 32'h0043_ea42, rd);
    bus(0, CBTC_STAT_ADDR, 0);
    cmp("status", 32'h0000_2364, rd);
    $display("test free segment 2 done");
  endtask
  task t_mode;
    int n;
    bus(1, CBTC_CTL_ADDR, 0);
    bus(1, CBTC_CFG_ADDR, 32'h0000_1302);
    bus(0, CBTC_CFG_ADDR, 0);
    cmp("cfg", 32'h0043_ea42, rd);
    n = 0;
    while (tick !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (tick !== 1'b1 && n < 20);
    cmp("quantum", 2 * (2 + 1), n);
    bus(1, CBTC_CTL_ADDR, {8'h0, CBTC_MODE_CONFIG, 21'h0});
    bus(1, CBTC_CFG_ADDR, 32'h0000_1302);
    bus(0, CBTC_CFG_ADDR, 0);
    cmp("cfg", 32'h0000_1302, rd);
    bus(0, CBTC_CTL_ADDR, 0);
    cmp("mode", {8'h0, CBTC_MODE_CONFIG, 21'h0}, rd);
    $display("test mode gate done");
  endtask
  task t_wake;
    logic seen;
    for (int i = 0; i < 3; i++)
    begin
      c = 32'h0000_1302 | (32'(i > 0) << CBTC_WAKE_LINE_FILTER_EN_BIT);
      bus(1, CBTC_CFG_ADDR, c);
      pulse((i == 1) ? 4'h1 : 4'h6);
      seen = 0;
      repeat (10) @(negedge mclk) if (wake === 1'b0) seen = 1;
      cmp("wake low", 32'(i != 1), 32'(seen));
      repeat (4) @(posedge mclk);
    end
    $display("test wake filter done");
  endtask
  task t_sample;
    logic seen;
    for (int i = 0; i < 3; i++)
    begin
      c = 32'h0000_1302 | (32'(i > 0) << CBTC_SAM_BIT);
      bus(1, CBTC_CFG_ADDR, c);
      bus(1, CBTC_CTL_ADDR, 0);
      pulse((i == 1) ? 4'h4 : 4'hf);
      seen = 0;
      repeat (48) @(negedge mclk) if (samp === 1'b0) seen = 1;
      cmp("sampled low", 32'(i != 1), 32'(seen));
      bus(1, CBTC_CTL_ADDR, {8'h0, CBTC_MODE_CONFIG, 21'h0});
    end
    $display("test sampling done");
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      test_done;
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    t_reset;
    t_auto_ph2;
    t_free;
    t_mode;
    t_wake;
    t_sample;
    test_done;
  end
endmodule
